//--- shared/pamb_defs.svh
// Register indices, field positions and reset values of the mailbox block.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef PAMB_DEFS_SVH
`define PAMB_DEFS_SVH

// ==========================================================================
// Register indices on both access ports
// ==========================================================================
`define PAMB_GRP_OUT 2'h0
`define PAMB_GRP_IN 2'h1
`define PAMB_IDX_FLAGS 4'h8
`define PAMB_IDX_INTCTL 4'h9
`define PAMB_IDX_CTRL 4'ha

// ==========================================================================
// Field positions
// ==========================================================================
`define PAMB_FLAG_RST_BIT 28
`define PAMB_A_EN_BIT 4
`define PAMB_A_SEL_LSB 0
`define PAMB_B_EN_BIT 12
`define PAMB_B_SEL_LSB 8
`define PAMB_A_PEND_BIT 16
`define PAMB_B_PEND_BIT 17

// ==========================================================================
// Reset values
// ==========================================================================
`define PAMB_FLAGS_RST 16'h0000
`define PAMB_SEL_RST 4'h0
`define PAMB_WORD_RST 32'h0000_0000
`define PAMB_BYTE_RST 8'h00

`endif

//--- shared/pamb_pkg.sv
// Types shared by the mailbox block.
// Assumes nothing of its surroundings.
package pamb_pkg;

   typedef logic [1:0] pamb_box_t;
   typedef logic [3:0] pamb_be_t;
   typedef logic [15:0] pamb_flags_t;
   typedef logic [31:0] pamb_word_t;

endpackage : pamb_pkg

//--- design/pamb_box_bank.sv
// Four 32-bit mailboxes in one direction with per-byte full flags.
// Assumes writer and reader strobes are one-cycle pulses on the same clock.
`include "pamb_defs.svh"

module pamb_box_bank
   import pamb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic flag_clr_i,
   input wire logic wr_i,
   input wire pamb_box_t wr_box_i,
   input wire pamb_be_t wr_be_i,
   input wire pamb_word_t wdata_i,
   input wire pamb_box_t own_box_i,
   output pamb_word_t own_rdata_o,
   input wire logic rd_i,
   input wire pamb_box_t rd_box_i,
   input wire pamb_be_t rd_be_i,
   output pamb_word_t rdata_o,
   output pamb_flags_t flags_o,
   output pamb_flags_t wr_ev_o,
   output pamb_flags_t rd_ev_o
);

   logic [7:0] mem [0:15];
   pamb_flags_t flags;
   pamb_flags_t next_flags;

   // =======================================================================
   // Per-byte write and read events
   // =======================================================================
   for (genvar k = 0; k < 16; k++) begin : g_ev
      assign wr_ev_o[k] = wr_i && (wr_box_i == 2'(k / 4)) && wr_be_i[k % 4];
      assign rd_ev_o[k] = rd_i && (rd_box_i == 2'(k / 4)) && rd_be_i[k % 4];
   end

   // A write sets the flag even when a read or a reset clears it at once.
   assign next_flags = (flag_clr_i ? `PAMB_FLAGS_RST : (flags & ~rd_ev_o))
                       | wr_ev_o;

   // =======================================================================
   // Storage and flags
   // =======================================================================
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) begin
            mem[i] <= `PAMB_BYTE_RST;
         end
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (wr_ev_o[i]) begin
               mem[i] <= wdata_i[8*(i%4) +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags <= `PAMB_FLAGS_RST;
      end else begin
         flags <= next_flags;
      end
   end

   assign flags_o = flags;
   assign rdata_o = {mem[{rd_box_i, 2'h3}], mem[{rd_box_i, 2'h2}],
                     mem[{rd_box_i, 2'h1}], mem[{rd_box_i, 2'h0}]};
   assign own_rdata_o = {mem[{own_box_i, 2'h3}], mem[{own_box_i, 2'h2}],
                         mem[{own_box_i, 2'h1}], mem[{own_box_i, 2'h0}]};

endmodule // pamb_box_bank

//--- design/pamb_irq_ctl.sv
// Interrupt control register of one side: two watched bytes, two pending
// bits cleared by writing one, and one interrupt level.
// Assumes event vectors are one-cycle pulses on the same clock.
`include "pamb_defs.svh"

module pamb_irq_ctl
   import pamb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_i,
   input wire pamb_be_t be_i,
   input wire pamb_word_t wdata_i,
   input wire pamb_flags_t ev_a_i,
   input wire pamb_flags_t ev_b_i,
   input wire pamb_flags_t hold_a_i,
   input wire pamb_flags_t hold_b_i,
   output pamb_word_t ctl_o,
   output logic irq_o
);

   logic en_a;
   logic en_b;
   logic [3:0] sel_a;
   logic [3:0] sel_b;
   logic pend_a;
   logic pend_b;
   logic hit_a;
   logic hit_b;
   logic clr_a;
   logic clr_b;
   logic next_pend_a;
   logic next_pend_b;

   // =======================================================================
   // Event and clear decode
   // =======================================================================
   assign hit_a = en_a && ev_a_i[sel_a];
   assign hit_b = en_b && ev_b_i[sel_b];
   // A clear is ignored while the watched byte is still full.
   assign clr_a = wr_i && be_i[2] && wdata_i[`PAMB_A_PEND_BIT]
                  && !hold_a_i[sel_a];
   assign clr_b = wr_i && be_i[2] && wdata_i[`PAMB_B_PEND_BIT]
                  && !hold_b_i[sel_b];
   assign next_pend_a = hit_a || (pend_a && !clr_a);
   assign next_pend_b = hit_b || (pend_b && !clr_b);

   // =======================================================================
   // Registers
   // =======================================================================
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_a <= 1'b0;
         sel_a <= `PAMB_SEL_RST;
      end else if (wr_i && be_i[0]) begin
         en_a <= wdata_i[`PAMB_A_EN_BIT];
         sel_a <= wdata_i[`PAMB_A_SEL_LSB +: 4];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_b <= 1'b0;
         sel_b <= `PAMB_SEL_RST;
      end else if (wr_i && be_i[1]) begin
         en_b <= wdata_i[`PAMB_B_EN_BIT];
         sel_b <= wdata_i[`PAMB_B_SEL_LSB +: 4];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_a <= 1'b0;
         pend_b <= 1'b0;
      end else begin
         pend_a <= next_pend_a;
         pend_b <= next_pend_b;
      end
   end

   assign ctl_o = {14'h0000, pend_b, pend_a, 3'h0, en_b, sel_b,
                   3'h0, en_a, sel_a};
   assign irq_o = pend_a || pend_b;

endmodule // pamb_irq_ctl

//--- design/pamb_mailbox.sv
// Mailbox status and interrupt logic between the host target port and the
// local add-on bus port.
// Assumes both access ports are driven by logic on ref_clk_i, with one-cycle
// read and write strobes, and that the reset pin is asynchronous.
//
// Summary of operation
// - A write to a full outgoing byte simply overwrites it, without error.
// - Host flags 15:0 show host outgoing bytes not yet read locally.
// - Local flags 31:16 show local outgoing bytes not yet read by host.
// - Local flags 15:0 show full incoming bytes; a local read clears both.
// - Host flags 31:16 show full incoming bytes; a host read clears them.
// - Host control bit 4 enables, bits 3:0 pick, local-read interrupt.
// - Host control bit 12 enables, bits 11:8 pick, local-write interrupt.
// - Local control bit 12 enables, bits 11:8 pick, host-read interrupt.
// - Local control bit 4 enables, bits 3:0 pick, host-write interrupt.
// - Each condition is enabled alone and watches one byte of one box.
// - Both conditions of one side are set by a single register write.
// - Host bits 16 and 17 are pending bits; writing one clears them.
// - Local bits 16 and 17 are pending bits; writing one clears them.
// - An incoming pending bit stays set while its watched byte is full.
// - The flag reset bit from either side clears every full flag not written in that cycle.
// - Any outgoing byte write sets its full flag in both status views.
// - The local interrupt drops as soon as both its pending bits are clear.
`include "pamb_defs.svh"

module pamb_mailbox
   import pamb_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic host_sel_i,
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [3:0] host_addr_i,
   input wire pamb_be_t host_be_i,
   input wire pamb_word_t host_wdata_i,
   output pamb_word_t host_rdata_o,
   output logic host_irq_n_o,
   input wire logic local_sel_i,
   input wire logic local_wr_i,
   input wire logic local_rd_i,
   input wire logic [3:0] local_addr_i,
   input wire pamb_be_t local_be_i,
   input wire pamb_word_t local_wdata_i,
   output pamb_word_t local_rdata_o,
   output logic local_irq_n_o
);

   // =======================================================================
   // Reset release
   // =======================================================================
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // =======================================================================
   // Access decode
   // =======================================================================
   wire host_wr = host_sel_i && host_wr_i;
   wire host_rd = host_sel_i && host_rd_i;
   wire local_wr = local_sel_i && local_wr_i;
   wire local_rd = local_sel_i && local_rd_i;
   wire host_grp_out = (host_addr_i[3:2] == `PAMB_GRP_OUT);
   wire host_grp_in = (host_addr_i[3:2] == `PAMB_GRP_IN);
   wire local_grp_out = (local_addr_i[3:2] == `PAMB_GRP_OUT);
   wire local_grp_in = (local_addr_i[3:2] == `PAMB_GRP_IN);
   wire host_wr_out = host_wr && host_grp_out;
   wire host_rd_in = host_rd && host_grp_in;
   wire local_wr_out = local_wr && local_grp_out;
   wire local_rd_in = local_rd && local_grp_in;
   wire host_wr_ictl = host_wr && (host_addr_i == `PAMB_IDX_INTCTL);
   wire local_wr_ictl = local_wr && (local_addr_i == `PAMB_IDX_INTCTL);
   wire host_wr_ctrl = host_wr && (host_addr_i == `PAMB_IDX_CTRL);
   wire local_wr_ctrl = local_wr && (local_addr_i == `PAMB_IDX_CTRL);

   // The flag reset bit is write-only and acts in the cycle it is written.
   wire flag_clr = (host_wr_ctrl && host_be_i[3]
                    && host_wdata_i[`PAMB_FLAG_RST_BIT])
                   || (local_wr_ctrl && local_be_i[3]
                       && local_wdata_i[`PAMB_FLAG_RST_BIT]);

   // =======================================================================
   // Mailbox banks
   // =======================================================================
   pamb_word_t hob_own;
   pamb_word_t hob_peer;
   pamb_flags_t hob_flags;
   pamb_flags_t hob_wr_ev;
   pamb_flags_t hob_rd_ev;
   pamb_word_t lob_own;
   pamb_word_t lob_peer;
   pamb_flags_t lob_flags;
   pamb_flags_t lob_wr_ev;
   pamb_flags_t lob_rd_ev;

   // Host outgoing boxes, seen locally as the local incoming boxes.
   pamb_box_bank u_host_out (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .flag_clr_i(flag_clr),
      .wr_i(host_wr_out),
      .wr_box_i(host_addr_i[1:0]),
      .wr_be_i(host_be_i),
      .wdata_i(host_wdata_i),
      .own_box_i(host_addr_i[1:0]),
      .own_rdata_o(hob_own),
      .rd_i(local_rd_in),
      .rd_box_i(local_addr_i[1:0]),
      .rd_be_i(local_be_i),
      .rdata_o(hob_peer),
      .flags_o(hob_flags),
      .wr_ev_o(hob_wr_ev),
      .rd_ev_o(hob_rd_ev)
   );

   // Local outgoing boxes, seen by the host as the host incoming boxes.
   pamb_box_bank u_local_out (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .flag_clr_i(flag_clr),
      .wr_i(local_wr_out),
      .wr_box_i(local_addr_i[1:0]),
      .wr_be_i(local_be_i),
      .wdata_i(local_wdata_i),
      .own_box_i(local_addr_i[1:0]),
      .own_rdata_o(lob_own),
      .rd_i(host_rd_in),
      .rd_box_i(host_addr_i[1:0]),
      .rd_be_i(host_be_i),
      .rdata_o(lob_peer),
      .flags_o(lob_flags),
      .wr_ev_o(lob_wr_ev),
      .rd_ev_o(lob_rd_ev)
   );

   // Both status views hold the same bits: incoming-to-host high,
   // host-outgoing low.
   wire pamb_word_t host_flags = {lob_flags, hob_flags};
   wire pamb_word_t local_flags = {lob_flags, hob_flags};

   // =======================================================================
   // Interrupt control
   // =======================================================================
   pamb_word_t host_ictl;
   pamb_word_t local_ictl;
   logic host_irq;
   logic local_irq;

   // Low condition watches local reads of host outgoing bytes, high
   // condition watches local writes of host incoming bytes.
   pamb_irq_ctl u_host_irq (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .wr_i(host_wr_ictl),
      .be_i(host_be_i),
      .wdata_i(host_wdata_i),
      .ev_a_i(hob_rd_ev),
      .ev_b_i(lob_wr_ev),
      .hold_a_i(`PAMB_FLAGS_RST),
      .hold_b_i(lob_flags),
      .ctl_o(host_ictl),
      .irq_o(host_irq)
   );

   // Low condition watches host writes of local incoming bytes, high
   // condition watches host reads of local outgoing bytes.
   pamb_irq_ctl u_local_irq (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .wr_i(local_wr_ictl),
      .be_i(local_be_i),
      .wdata_i(local_wdata_i),
      .ev_a_i(hob_wr_ev),
      .ev_b_i(lob_rd_ev),
      .hold_a_i(hob_flags),
      .hold_b_i(`PAMB_FLAGS_RST),
      .ctl_o(local_ictl),
      .irq_o(local_irq)
   );

   assign host_irq_n_o = !host_irq;
   assign local_irq_n_o = !local_irq;

   // =======================================================================
   // Read data
   // =======================================================================
   // Unmapped indices and the write-only control register read as zero.
   wire pamb_word_t host_rmux =
      host_grp_out ? hob_own :
      host_grp_in ? lob_peer :
      (host_addr_i == `PAMB_IDX_FLAGS) ? host_flags :
      (host_addr_i == `PAMB_IDX_INTCTL) ? host_ictl : `PAMB_WORD_RST;
   wire pamb_word_t local_rmux =
      local_grp_out ? lob_own :
      local_grp_in ? hob_peer :
      (local_addr_i == `PAMB_IDX_FLAGS) ? local_flags :
      (local_addr_i == `PAMB_IDX_INTCTL) ? local_ictl : `PAMB_WORD_RST;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata_o <= `PAMB_WORD_RST;
      end else if (host_rd) begin
         host_rdata_o <= host_rmux;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         local_rdata_o <= `PAMB_WORD_RST;
      end else if (local_rd) begin
         local_rdata_o <= local_rmux;
      end
   end

endmodule // pamb_mailbox

//--- sim/pamb_mailbox_assertions.sv
// Port-level checks of the mailbox block.
// Assumes one clock and the asynchronous active-low reset pin.
`include "pamb_defs.svh"

module pamb_mailbox_checker
   import pamb_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic host_sel_i,
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [3:0] host_addr_i,
   input wire pamb_word_t host_rdata_o,
   input wire logic host_irq_n_o,
   input wire logic local_sel_i,
   input wire logic local_wr_i,
   input wire logic local_rd_i,
   input wire logic [3:0] local_addr_i,
   input wire pamb_word_t local_rdata_o,
   input wire logic local_irq_n_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==================================================================
   // Access decode
   // ==================================================================
   wire logic h_wr = host_sel_i && host_wr_i;
   wire logic h_rd = host_sel_i && host_rd_i;
   wire logic l_wr = local_sel_i && local_wr_i;
   wire logic l_rd = local_sel_i && local_rd_i;
   wire logic h_acc = h_wr || h_rd;
   wire logic l_acc = l_wr || l_rd;

   // ==================================================================
   // Properties
   // ==================================================================
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_quiet;
      (host_irq_n_o && local_irq_n_o) [*3];
   endsequence

   reset_quiet_a: assert property ($rose(rst_n_i) |-> s_quiet)
      else $error("interrupt active just after reset");
   host_cause_a: assert property ($fell(host_irq_n_o) |->
      $past(l_acc) || $past(l_acc, 2))
      else $error("host interrupt without a local access");
   local_cause_a: assert property ($fell(local_irq_n_o) |->
      $past(h_acc) || $past(h_acc, 2))
      else $error("local interrupt without a host access");
   host_clear_a: assert property ($rose(host_irq_n_o) |->
      $past(h_wr) || $past(h_wr, 2))
      else $error("host interrupt dropped without a host write");
   local_clear_a: assert property ($rose(local_irq_n_o) |->
      $past(l_wr))
      else $error("local interrupt dropped without a local write");
   host_hold_a: assert property (!h_rd |=> $stable(host_rdata_o))
      else $error("host read data moved without a read");
   local_hold_a: assert property (!l_rd |=> $stable(local_rdata_o))
      else $error("local read data moved without a read");
   host_blank_a: assert property (
      h_rd && host_addr_i >= `PAMB_IDX_CTRL |=> host_rdata_o == 32'h0)
      else $error("host control or unmapped read not zero");
   local_blank_a: assert property (
      l_rd && local_addr_i >= `PAMB_IDX_CTRL |=> local_rdata_o == 32'h0)
      else $error("local control or unmapped read not zero");
endmodule // pamb_mailbox_checker

bind pamb_mailbox pamb_mailbox_checker i_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .host_sel_i(host_sel_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
   .host_addr_i(host_addr_i), .host_rdata_o(host_rdata_o),
   .host_irq_n_o(host_irq_n_o), .local_sel_i(local_sel_i),
   .local_wr_i(local_wr_i), .local_rd_i(local_rd_i),
   .local_addr_i(local_addr_i), .local_rdata_o(local_rdata_o),
   .local_irq_n_o(local_irq_n_o));

//--- sim/pamb_port_bfm.sv
// Register port master standing in for the host or the local processor.
// Assumes the port takes a strobe on the rising edge of clk_i.
`include "pamb_defs.svh"

module pamb_port_bfm
   import pamb_pkg::*;
(
   input wire logic clk_i,
   output logic sel_o,
   output logic wr_o,
   output logic rd_o,
   output logic [3:0] addr_o,
   output pamb_be_t be_o,
   output pamb_word_t wdata_o,
   input wire pamb_word_t rdata_i
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sel_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 4'h0;
      be_o = 4'h0;
      wdata_o = 32'h0;
   end

   // One access; released lines show inverted values afterwards.
   task xfer(input logic w, input logic [3:0] a, input pamb_be_t b,
      input pamb_word_t d, output pamb_word_t q);
      @(posedge clk_i);
      #1;
      sel_o = 1'b1;
      wr_o = w;
      rd_o = !w;
      addr_o = a;
      be_o = b;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      q = rdata_i;
      sel_o = 1'b0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~a;
      be_o = ~b;
      wdata_o = ~d;
   endtask

   // Reads the flags until the masked bytes are empty or 20 reads have been made.
   task poll(input pamb_word_t mask);
      pamb_word_t q;
      int n;
      n = 0;
      q = mask;
      while ((q & mask) !== 32'h0 && n < 20) begin
         xfer(1'b0, `PAMB_IDX_FLAGS, 4'hf, 32'h0, q);
         n++;
      end
   endtask
endmodule // pamb_port_bfm

//--- sim/tb.sv
// Self-checking bench of the mailbox block through both register ports.
// Assumes the checker is bound to the block by its own file.
module tb
   import pamb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst_n, h_sel, h_wr, h_rd, h_irq_n, l_sel, l_wr, l_rd, l_irq_n;
   logic [3:0] h_addr, l_addr;
   pamb_be_t h_be, l_be;
   pamb_word_t h_wd, l_wd, h_rdata, l_rdata;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;

   pamb_mailbox i_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
      .host_sel_i(h_sel), .host_wr_i(h_wr), .host_rd_i(h_rd),
      .host_addr_i(h_addr), .host_be_i(h_be), .host_wdata_i(h_wd),
      .host_rdata_o(h_rdata), .host_irq_n_o(h_irq_n),
      .local_sel_i(l_sel), .local_wr_i(l_wr), .local_rd_i(l_rd),
      .local_addr_i(l_addr), .local_be_i(l_be), .local_wdata_i(l_wd),
      .local_rdata_o(l_rdata), .local_irq_n_o(l_irq_n));
   pamb_port_bfm i_host (.clk_i(clk), .sel_o(h_sel), .wr_o(h_wr),
      .rd_o(h_rd), .addr_o(h_addr), .be_o(h_be), .wdata_o(h_wd),
      .rdata_i(h_rdata));
   pamb_port_bfm i_local (.clk_i(clk), .sel_o(l_sel), .wr_o(l_wr),
      .rd_o(l_rd), .addr_o(l_addr), .be_o(l_be), .wdata_o(l_wd),
      .rdata_i(l_rdata));

   // ==================================================================
   // Tasks
   // ==================================================================
   task complete_run;
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task chk(input string n, input pamb_word_t e, input pamb_word_t g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", n, e, g);
      end
   endtask

   task wrt(input bit h, input logic [3:0] a, input pamb_be_t b,
      input pamb_word_t d);
      pamb_word_t q;
      if (h) i_host.xfer(1'b1, a, b, d, q);
      else i_local.xfer(1'b1, a, b, d, q);
   endtask

   task rdc(input bit h, input logic [3:0] a, input pamb_be_t b,
      input pamb_word_t e, input string n);
      pamb_word_t q;
      if (h) i_host.xfer(1'b0, a, b, 32'h0, q);
      else i_local.xfer(1'b0, a, b, 32'h0, q);
      chk(n, e, q);
   endtask

   // Checks an interrupt pin, after one more edge when wt is set.
   task irq(input bit h, input logic e, input bit wt);
      if (wt) begin
         @(posedge clk);
         #1;
      end
      chk(h ? "host_irq_n" : "local_irq_n", {31'h0, e},
         {31'h0, h ? h_irq_n : l_irq_n});
   endtask

   // ==================================================================
   // Clock, reset, timeout and tests
   // ==================================================================
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      rdc(1, 4'h8, 4'hf, 32'h0, "host flags");
      rdc(1, 4'h9, 4'hf, 32'h0, "host ictl");
      rdc(0, 4'h8, 4'hf, 32'h0, "local flags");
      rdc(0, 4'h9, 4'hf, 32'h0, "local ictl");
      irq(1, 1'b1, 0);
      irq(0, 1'b1, 0);
      $display("test reset done");
      i_host.poll(32'h0000_000f);
      wrt(1, 4'h0, 4'h3, 32'h1122_3344);
      rdc(1, 4'h8, 4'hf, 32'h0000_0003, "host flags");
      rdc(0, 4'h8, 4'hf, 32'h0000_0003, "local flags");
      wrt(1, 4'h0, 4'h1, 32'h0000_00aa);
      rdc(0, 4'h4, 4'hf, 32'h0000_33aa, "local box0");
      rdc(0, 4'h8, 4'hf, 32'h0, "local flags");
      wrt(0, 4'h2, 4'h8, 32'h5500_0000);
      rdc(1, 4'h8, 4'hf, 32'h0800_0000, "host flags");
      rdc(1, 4'h6, 4'h8, 32'h5500_0000, "host box6");
      rdc(0, 4'h8, 4'hf, 32'h0, "local flags");
      $display("test flags done");
      wrt(1, 4'h9, 4'h3, 32'h0000_1d16);
      rdc(1, 4'h9, 4'hf, 32'h0000_1d16, "host ictl");
      rdc(0, 4'h5, 4'h2, 32'h0, "local box5");
      irq(1, 1'b1, 1);
      rdc(0, 4'h5, 4'h4, 32'h0, "local box5");
      irq(1, 1'b0, 1);
      rdc(1, 4'h9, 4'hf, 32'h0001_1d16, "host ictl");
      wrt(1, 4'h9, 4'h4, 32'h0001_0000);
      irq(1, 1'b1, 1);
      wrt(0, 4'h3, 4'h2, 32'h0000_7700);
      irq(1, 1'b0, 1);
      wrt(1, 4'h9, 4'h4, 32'h0002_0000);
      rdc(1, 4'h9, 4'hf, 32'h0002_1d16, "host ictl");
      irq(1, 1'b0, 1);
      rdc(1, 4'h7, 4'h2, 32'h0000_7700, "host box7");
      rdc(1, 4'h8, 4'hf, 32'h0, "host flags");
      wrt(1, 4'h9, 4'h4, 32'h0002_0000);
      irq(1, 1'b1, 1);
      rdc(1, 4'h9, 4'hf, 32'h0000_1d16, "host ictl");
      $display("test host irq done");
      wrt(0, 4'h9, 4'h3, 32'h0000_1b10);
      wrt(1, 4'h0, 4'h1, 32'h0000_0042);
      irq(0, 1'b0, 1);
      rdc(0, 4'h9, 4'hf, 32'h0001_1b10, "local ictl");
      wrt(0, 4'h9, 4'h4, 32'h0001_0000);
      irq(0, 1'b0, 1);
      wrt(0, 4'h2, 4'h8, 32'h9900_0000);
      rdc(0, 4'h8, 4'hf, 32'h0800_0001, "local flags");
      wrt(0, 4'ha, 4'h8, 32'h1000_0000);
      rdc(1, 4'h8, 4'hf, 32'h0, "host flags");
      wrt(0, 4'h9, 4'h4, 32'h0001_0000);
      irq(0, 1'b1, 0);
      rdc(1, 4'h6, 4'h8, 32'h9900_0000, "host box6");
      irq(0, 1'b0, 1);
      rdc(0, 4'h9, 4'hf, 32'h0002_1b10, "local ictl");
      wrt(0, 4'h9, 4'h4, 32'h0002_0000);
      irq(0, 1'b1, 0);
      $display("test local irq done");
      wrt(0, 4'h9, 4'h3, 32'h0);
      wrt(1, 4'h0, 4'hf, 32'h0);
      irq(0, 1'b1, 1);
      rdc(0, 4'h8, 4'hf, 32'h0000_000f, "local flags");
      wrt(1, 4'ha, 4'h8, 32'h1000_0000);
      rdc(0, 4'h8, 4'hf, 32'h0, "local flags");
      rdc(1, 4'ha, 4'hf, 32'h0, "host ctrl");
      rdc(1, 4'hb, 4'hf, 32'h0, "host unmapped");
      $display("test reset bit done");
      complete_run();
   end
endmodule // tb
